/* File: logic/ler_pkg.sv */
// Constants and carrier types for the lane edge-rate configuration block.
// Assumes a byte-wide serial register port and 2-bit slew codes per lane.
package ler_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets and field positions
	localparam logic [7:0] LER_OFS_LP_CLK = 8'h0A;
	localparam logic [7:0] LER_OFS_HS_DATA = 8'h0B;
	localparam int LER_POS_A0_LP = 6;
	localparam int LER_POS_B_LP = 4;
	localparam int LER_POS_CLK_HS = 0;
	localparam int LER_POS_B3_HS = 6;
	localparam int LER_POS_B2_HS = 4;
	localparam int LER_POS_B1_HS = 2;
	localparam int LER_POS_B0_HS = 0;
	localparam logic [7:0] LER_RSV_MASK_LP_CLK = 8'h0C;

	////////////////////////////////////////////////////////////////////////
	// Reset values and codes
	localparam logic [1:0] LER_RST_A0_LP = 2'h0;
	localparam logic [1:0] LER_RST_FIELD = 2'h0;
	localparam logic [1:0] LER_STRAP_LOW = 2'h0;
	localparam logic [1:0] LER_STRAP_MID = 2'h1;
	localparam logic [1:0] LER_HS_CODE_LOW = 2'h0;
	localparam logic [1:0] LER_HS_CODE_MID = 2'h1;
	localparam logic [1:0] LER_HS_CODE_HIGH = 2'h2;
	// Low-power codes and their rank, 0 fastest to 3 slowest
	localparam logic [1:0] LER_LP_CODE_MIDDLE = 2'h0;
	localparam logic [1:0] LER_LP_CODE_SLOWISH = 2'h1;
	localparam logic [1:0] LER_LP_CODE_FAST = 2'h2;
	localparam logic [1:0] LER_LP_RANK_FAST = 2'h0;
	localparam logic [1:0] LER_LP_RANK_MIDDLE = 2'h1;
	localparam logic [1:0] LER_LP_RANK_SLOWISH = 2'h2;
	localparam logic [1:0] LER_LP_RANK_SLOWEST = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Timing counts
	localparam int LER_SYNC_STAGES = 2;
	localparam logic [1:0] LER_STRAP_LOAD_CNT = 2'h2;
	localparam logic [3:0] LER_BITS_PER_BYTE = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [1:0] lane_a0_lp_slew_sel;
		logic [1:0] lanes_b_lp_slew_sel;
		logic [1:0] clock_lane_hs_slew_sel;
		logic [1:0] lane_b3_hs_slew_sel;
		logic [1:0] lane_b2_hs_slew_sel;
		logic [1:0] lane_b1_hs_slew_sel;
		logic [1:0] lane_b0_hs_slew_sel;
	} ler_slew_t;

	typedef struct packed {
		logic [1:0] lane_a0_lp_rank;
		logic [1:0] lanes_b_lp_rank;
	} ler_lp_rank_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_SUB = 4'h3,
		ST_SUB_ACK = 4'h4,
		ST_WDATA = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA = 4'h7,
		ST_RDATA_ACK = 4'h8
	} ler_state_t;

endpackage

/* File: logic/ler_sync.sv */
// Two-stage synchroniser, one chain per bit.
// Assumes inputs come from pins outside the ref_clk_i domain.
`timescale 1ns/1ps
module ler_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic device_reset_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	import ler_pkg::*;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			logic [LER_SYNC_STAGES-1:0] chain;
			// Only the last stage is ever read
			always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
			begin
				if (!device_reset_n_i)
					chain <= '0;
				else
					chain <= {chain[LER_SYNC_STAGES-2:0], async_i[gi]};
			end
			assign sync_o[gi] = chain[LER_SYNC_STAGES-1];
		end
	endgenerate
endmodule

/* File: logic/ler_lp_decode.sv */
// Decodes low-power slew codes into a speed rank for the transmitters.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module ler_lp_decode (
	input wire logic [3:0] code_i,
	output logic [3:0] rank_o
);
	import ler_pkg::*;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_lane
			always_comb
			begin
				case (code_i[2*gi +: 2])
					LER_LP_CODE_FAST: rank_o[2*gi +: 2] = LER_LP_RANK_FAST;
					LER_LP_CODE_MIDDLE: rank_o[2*gi +: 2] = LER_LP_RANK_MIDDLE;
					LER_LP_CODE_SLOWISH: rank_o[2*gi +: 2] = LER_LP_RANK_SLOWISH;
					default: rank_o[2*gi +: 2] = LER_LP_RANK_SLOWEST;
				endcase
			end
		end
	endgenerate
endmodule

/* File: logic/ler_regs.sv */
// Edge-rate configuration registers behind a serial register port.
// Assumes scl/sda and straps are raw pins; the sda wire is resolved outside.
//
// Contract
// - 0x0A[7:6] holds lane A0 low-power slew, read/write, resets to 00.
// - Low-power codes: 00 middle, 01 slower, 10 fastest, 11 slowest.
// - 0x0A[5:4] holds B-lane low-power slew, loaded from two config straps.
// - Software writes replace any strap-loaded value until next reset.
// - 0x0A[1:0] holds clock-lane high-speed slew, strap-loaded then read/write.
// - Strap low gives 00, mid 01, high 10; 11 only by software.
// - 0x0B[7:6] holds B lane 3 high-speed slew, strap-loaded, writable.
// - 0x0B[5:4] holds B lane 2 high-speed slew, strap-loaded, writable.
// - 0x0B[3:2] holds B lane 1 high-speed slew, strap-loaded, writable.
// - 0x0B[1:0] holds B lane 0 high-speed slew, strap-loaded, writable.
// - Straps are sampled on the third clock edge after device reset rises and loaded into fields.
`timescale 1ns/1ps
module ler_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h2C // Arbitrary value
) (
	input wire logic ref_clk_i,
	input wire logic device_reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [1:0] slew_strap_pin_i,
	input wire logic [1:0] cfg_strap_i,
	output ler_pkg::ler_slew_t slew_o,
	output ler_pkg::ler_lp_rank_t lp_rank_o,
	output logic straps_loaded_o
);
	import ler_pkg::*;

	logic scl_s;
	logic sda_s;
	logic [1:0] erc_s;
	logic [1:0] cfg_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [1:0] load_cnt;
	logic strap_load;
	logic [1:0] hs_strap_code;
	ler_slew_t slew;
	ler_state_t state;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic [7:0] ptr;
	logic rw;
	logic acked;
	logic [7:0] rd_byte;
	logic wr_stb;
	logic [3:0] rank;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	ler_sync #(.W(6)) u_sync (
		.ref_clk_i(ref_clk_i),
		.device_reset_n_i(device_reset_n_i),
		.async_i({scl_i, sda_i, slew_strap_pin_i, cfg_strap_i}),
		.sync_o({scl_s, sda_s, erc_s, cfg_s})
	);

	// Delayed copies for edge detection; idle level of both pins is high
	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
			{scl_q, sda_q} <= 2'h3;
		else
			{scl_q, sda_q} <= {scl_s, sda_s};
	end

	assign scl_rise = scl_s & ~scl_q & straps_loaded_o;
	assign scl_fall = ~scl_s & scl_q & straps_loaded_o;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s & straps_loaded_o;
	assign stop_det = scl_s & scl_q & ~sda_q & sda_s & straps_loaded_o;

	////////////////////////////////////////////////////////////////////////
	// Strap capture
	// Sync chain needs its depth in edges after release before it is valid
	// Capture after release
	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
		begin
			load_cnt <= 2'h0;
			straps_loaded_o <= 1'b0;
		end
		else if (!straps_loaded_o)
		begin
			load_cnt <= load_cnt + 2'h1;
			straps_loaded_o <= (load_cnt == LER_STRAP_LOAD_CNT);
		end
	end

	assign strap_load = !straps_loaded_o && (load_cnt == LER_STRAP_LOAD_CNT);

	always_comb
	begin
		case (erc_s)
			LER_STRAP_LOW: hs_strap_code = LER_HS_CODE_LOW;
			LER_STRAP_MID: hs_strap_code = LER_HS_CODE_MID;
			default: hs_strap_code = LER_HS_CODE_HIGH;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register fields
	assign wr_stb = scl_fall && (state == ST_WDATA) && (bit_cnt == LER_BITS_PER_BYTE);

	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
			slew.lane_a0_lp_slew_sel <= LER_RST_A0_LP;
		else if (wr_stb && ptr == LER_OFS_LP_CLK)
			slew.lane_a0_lp_slew_sel <= shreg[LER_POS_A0_LP +: 2];
	end

	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
		begin
			slew.lanes_b_lp_slew_sel <= LER_RST_FIELD;
			slew.clock_lane_hs_slew_sel <= LER_RST_FIELD;
		end
		else if (strap_load)
		begin
			slew.lanes_b_lp_slew_sel <= cfg_s;
			slew.clock_lane_hs_slew_sel <= hs_strap_code;
		end
		else if (wr_stb && ptr == LER_OFS_LP_CLK)
		begin
			slew.lanes_b_lp_slew_sel <= shreg[LER_POS_B_LP +: 2];
			slew.clock_lane_hs_slew_sel <= shreg[LER_POS_CLK_HS +: 2];
		end
	end

	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
		begin
			slew.lane_b3_hs_slew_sel <= LER_RST_FIELD;
			slew.lane_b2_hs_slew_sel <= LER_RST_FIELD;
			slew.lane_b1_hs_slew_sel <= LER_RST_FIELD;
			slew.lane_b0_hs_slew_sel <= LER_RST_FIELD;
		end
		else if (strap_load)
		begin
			slew.lane_b3_hs_slew_sel <= hs_strap_code;
			slew.lane_b2_hs_slew_sel <= hs_strap_code;
			slew.lane_b1_hs_slew_sel <= hs_strap_code;
			slew.lane_b0_hs_slew_sel <= hs_strap_code;
		end
		else if (wr_stb && ptr == LER_OFS_HS_DATA)
		begin
			slew.lane_b3_hs_slew_sel <= shreg[LER_POS_B3_HS +: 2];
			slew.lane_b2_hs_slew_sel <= shreg[LER_POS_B2_HS +: 2];
			slew.lane_b1_hs_slew_sel <= shreg[LER_POS_B1_HS +: 2];
			slew.lane_b0_hs_slew_sel <= shreg[LER_POS_B0_HS +: 2];
		end
	end

	always_comb
	begin
		case (ptr)
			LER_OFS_LP_CLK: rd_byte = {slew.lane_a0_lp_slew_sel, slew.lanes_b_lp_slew_sel,
				2'h0, slew.clock_lane_hs_slew_sel} & ~LER_RSV_MASK_LP_CLK;
			LER_OFS_HS_DATA: rd_byte = {slew.lane_b3_hs_slew_sel, slew.lane_b2_hs_slew_sel,
				slew.lane_b1_hs_slew_sel, slew.lane_b0_hs_slew_sel};
			default: rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter controls, registered
	ler_lp_decode u_dec (
		.code_i({slew.lane_a0_lp_slew_sel, slew.lanes_b_lp_slew_sel}),
		.rank_o(rank)
	);

	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
			{lp_rank_o, slew_o} <= '0;
		else
			{lp_rank_o, slew_o} <= {rank, slew};
	end

	////////////////////////////////////////////////////////////////////////
	// Serial register port
	// Open drain: the pin is only ever pulled low
	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// Bit capture on clock rise
	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
		begin
			shreg <= 8'h00;
			bit_cnt <= 4'h0;
			acked <= 1'b0;
		end
		else if (start_det)
			bit_cnt <= 4'h0;
		else if (scl_rise)
		begin
			if (state == ST_ADDR || state == ST_SUB || state == ST_WDATA)
			begin
				shreg <= {shreg[6:0], sda_s};
				bit_cnt <= bit_cnt + 4'h1;
			end
			else if (state == ST_RDATA)
			begin
				shreg <= {shreg[6:0], 1'b0};
				bit_cnt <= bit_cnt + 4'h1;
			end
			else if (state == ST_RDATA_ACK)
				acked <= ~sda_s;
		end
		else if (scl_fall)
		begin
			if (state == ST_ADDR_ACK && rw)
			begin
				shreg <= rd_byte;
				bit_cnt <= 4'h0;
			end
			else if (state == ST_RDATA_ACK && acked)
			begin
				shreg <= rd_byte;
				bit_cnt <= 4'h0;
			end
			else if (state == ST_ADDR_ACK || state == ST_SUB_ACK || state == ST_WDATA_ACK)
				bit_cnt <= 4'h0;
		end
	end

	// Sequencing, acknowledge drive and pointer
	// Sub-address then data
	always_ff @(posedge ref_clk_i or negedge device_reset_n_i)
	begin
		if (!device_reset_n_i)
		begin
			state <= ST_IDLE;
			sda_oe_o <= 1'b0;
			ptr <= 8'h00;
			rw <= 1'b0;
		end
		else if (start_det)
		begin
			state <= ST_ADDR;
			sda_oe_o <= 1'b0;
		end
		else if (stop_det)
		begin
			state <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end
		else if (scl_fall)
		begin
			case (state)
				ST_ADDR:
					if (bit_cnt == LER_BITS_PER_BYTE)
					begin
						// Foreign addresses are left unanswered
						state <= (shreg[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
						sda_oe_o <= (shreg[7:1] == DEV_ADDR);
						rw <= shreg[0];
					end
				ST_ADDR_ACK:
				begin
					state <= rw ? ST_RDATA : ST_SUB;
					sda_oe_o <= rw & ~rd_byte[7];
				end
				ST_SUB:
					if (bit_cnt == LER_BITS_PER_BYTE)
					begin
						state <= ST_SUB_ACK;
						sda_oe_o <= 1'b1;
						ptr <= shreg;
					end
				ST_SUB_ACK:
				begin
					state <= ST_WDATA;
					sda_oe_o <= 1'b0;
				end
				ST_WDATA:
					if (bit_cnt == LER_BITS_PER_BYTE)
					begin
						state <= ST_WDATA_ACK;
						sda_oe_o <= 1'b1;
						ptr <= ptr + 8'h01;
					end
				ST_WDATA_ACK:
				begin
					state <= ST_WDATA;
					sda_oe_o <= 1'b0;
				end
				ST_RDATA:
					if (bit_cnt == LER_BITS_PER_BYTE)
					begin
						state <= ST_RDATA_ACK;
						sda_oe_o <= 1'b0;
						ptr <= ptr + 8'h01;
					end
					else
						sda_oe_o <= ~shreg[7];
				ST_RDATA_ACK:
				begin
					state <= acked ? ST_RDATA : ST_IDLE;
					sda_oe_o <= acked & ~rd_byte[7];
				end
				default:
				begin
					state <= ST_IDLE;
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end
endmodule

/* File: test/ler_checker.sv */
// Port checker for the edge-rate register block.
// Assumes straps stay stable from reset until they are loaded.
`timescale 1ns/1ps
module ler_checker (
	input wire logic ref_clk_i,
	input wire logic device_reset_n_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [1:0] slew_strap_pin_i,
	input wire logic [1:0] cfg_strap_i,
	input wire ler_pkg::ler_slew_t slew_o,
	input wire ler_pkg::ler_lp_rank_t lp_rank_o,
	input wire logic straps_loaded_o
);
	import ler_pkg::*;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!device_reset_n_i);
	logic [1:0] hs_exp;
	// Three-level strap: code 11 counts as high
	assign hs_exp = slew_strap_pin_i[1] ? 2'h2 : slew_strap_pin_i;
	function automatic logic [1:0] rk(input logic [1:0] c);
		return (c == 2'h2) ? 2'h0 : (c == 2'h0) ? 2'h1 : (c == 2'h1) ? 2'h2 : 2'h3;
	endfunction
	sequence loaded_s;
		$rose(straps_loaded_o);
	endsequence
	////////////////////////////////////////////////////////////////
	chk_load_after_reset: assert property ($rose(device_reset_n_i) |-> ##[2:4] straps_loaded_o)
		else $error("straps not loaded in time");
	chk_loaded_holds: assert property (straps_loaded_o |=> straps_loaded_o)
		else $error("load flag dropped");
	chk_quiet_before_load: assert property (!straps_loaded_o |-> slew_o == '0 && !sda_oe_o)
		else $error("activity before strap load");
	chk_strap_lp_field: assert property (loaded_s |=> slew_o[11:10] == cfg_strap_i
		&& slew_o[13:12] == LER_RST_A0_LP) else $error("low-power fields wrong after load");
	chk_hs_strap_map: assert property (loaded_s |=> slew_o[9:0] == {5{hs_exp}})
		else $error("high-speed fields wrong after load");
	// Rank and code copies are registered on the same edge
	chk_rank_decode: assert property (straps_loaded_o && $past(straps_loaded_o) |->
		lp_rank_o == {rk(slew_o[13:12]), rk(slew_o[11:10])})
		else $error("rank does not follow codes");
	chk_write_on_byte_end: assert property ($past(straps_loaded_o, 2) && $changed(slew_o)
		|-> !scl_i) else $error("field changed while clock high");
	chk_sda_open_drain: assert property (sda_oe_o |-> !sda_o)
		else $error("data line driven high");
endmodule
bind ler_regs ler_checker ler_checker_i (.ref_clk_i, .device_reset_n_i, .scl_i, .sda_o, .sda_oe_o,
	.slew_strap_pin_i, .cfg_strap_i, .slew_o, .lp_rank_o, .straps_loaded_o);

/* File: test/ler_host.sv */
// Host model for the serial register port.
// Assumes the bench resolves the pulled-up data wire into sda_i.
`timescale 1ns/1ps
module ler_host (
	input wire logic ref_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Ten clocks a half period keeps clear of the sync delay
	task automatic hp;
		repeat (10) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic start;
		sda_o = 1'b1;
		hp;
		scl_o = 1'b1;
		hp;
		sda_o = 1'b0;
		hp;
		scl_o = 1'b0;
		hp;
	endtask
	task automatic stop;
		sda_o = 1'b0;
		hp;
		scl_o = 1'b1;
		hp;
		sda_o = 1'b1;
		hp;
	endtask
	// MSB first, ninth bit is the acknowledge
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 8; i >= 0; i--)
		begin
			sda_o = (i > 0) ? d[i-1] : a;
			hp;
			scl_o = 1'b1;
			hp;
			if (i > 0)
				q[i-1] = sda_i;
			else
				k = sda_i;
			scl_o = 1'b0;
			hp;
		end
	endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the edge-rate registers.
// Assumes host model and checker are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
	import ler_pkg::*;
	localparam logic [6:0] ADR = 7'h2C;
	logic ref_clk_i;
	logic device_reset_n_i;
	logic [1:0] strap;
	logic [1:0] cfg;
	logic scl;
	logic sda_h;
	logic sda_o;
	logic sda_oe;
	wire logic sda = sda_h & (sda_oe ? sda_o : 1'b1);
	ler_slew_t slew;
	ler_lp_rank_t rank;
	logic loaded;
	int err_count;
	int comparisons;
	logic [7:0] q;
	logic k;
	ler_regs #(.DEV_ADDR(ADR)) ler_regs_i (.ref_clk_i, .device_reset_n_i, .scl_i(scl), .sda_i(sda),
		.sda_o, .sda_oe_o(sda_oe), .slew_strap_pin_i(strap), .cfg_strap_i(cfg),
		.slew_o(slew), .lp_rank_o(rank), .straps_loaded_o(loaded));
	ler_host ler_host_i (.ref_clk_i, .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [1:0] rk(input logic [1:0] c);
		return (c == 2'h2) ? 2'h0 : (c == 2'h0) ? 2'h1 : (c == 2'h1) ? 2'h2 : 2'h3;
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic rst(input logic [1:0] s, input logic [1:0] c);
		device_reset_n_i = 1'b0;
		strap = s;
		cfg = c;
		repeat (4) @(posedge ref_clk_i);
		#1;
		device_reset_n_i = 1'b1;
		for (int i = 0; i < 20 && loaded !== 1'b1; i++)
			@(posedge ref_clk_i);
		repeat (3) @(posedge ref_clk_i);
		#1;
		`CHK(loaded, 1'b1)
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		ler_host_i.start();
		ler_host_i.xfer({ADR, 1'b0}, 1'b1, q, k);
		ler_host_i.xfer(o, 1'b1, q, k);
		ler_host_i.xfer(d, 1'b1, q, k);
		`CHK(k, 1'b0)
		ler_host_i.stop();
	endtask
	task automatic rd(input logic [7:0] o, input logic [7:0] e);
		ler_host_i.start();
		ler_host_i.xfer({ADR, 1'b0}, 1'b1, q, k);
		`CHK(k, 1'b0)
		ler_host_i.xfer(o, 1'b1, q, k);
		ler_host_i.start();
		ler_host_i.xfer({ADR, 1'b1}, 1'b1, q, k);
		ler_host_i.xfer(8'hFF, 1'b1, q, k);
		ler_host_i.stop();
		`CHK(q, e)
	endtask
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		err_count++;
		close_out();
	end
	initial
	begin
		err_count = 0;
		comparisons = 0;
		rst(2'h3, 2'h2);
		`CHK(slew, 14'h0AAA)
		`CHK(rank, 4'h4)
		rd(8'h0A, 8'h22);
		rd(8'h0B, 8'hAA);
		rd(8'h0C, 8'h00);
		ler_host_i.start();
		ler_host_i.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, q, k);
		`CHK(k, 1'b1)
		ler_host_i.stop();
		$display("Test strap load and read done");
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h0A, {c[1:0], ~c[1:0], 2'h3, c[1:0]});
			rd(8'h0A, {c[1:0], ~c[1:0], 2'h0, c[1:0]});
			`CHK(slew[13:8], {c[1:0], ~c[1:0], c[1:0]})
			`CHK(rank, {rk(c[1:0]), rk(~c[1:0])})
		end
		wr(8'h0B, 8'h1B);
		rd(8'h0B, 8'h1B);
		`CHK(slew[7:0], 8'h1B)
		$display("Test software writes done");
		// Reset must drop software values in favour of straps
		for (int s = 0; s < 3; s++)
		begin
			rst(s[1:0], ~s[1:0]);
			`CHK(slew, {2'h0, ~s[1:0], {5{s[1:0]}}})
			rd(8'h0B, {4{s[1:0]}});
		end
		$display("Test strap codes done");
		close_out();
	end
endmodule
